// *** inc/dlsd_pkg.sv ***
// Shared types and constants for the dual lane SIMD compute datapath.
// Assumes a single core clock; mode bits and instructions come from the sequencer.
package dlsd_pkg;
	localparam int DLSD_DW     = 40;           // Data register width
	localparam int DLSD_NREG   = 32;           // Registers per lane
	localparam int DLSD_IDXW   = 4;            // Register index width per name space
	localparam int DLSD_BUSW   = 64;           // Memory bus width
	localparam int DLSD_PADW   = 8;            // Low pad bits under a 32-bit value
	localparam int DLSD_LANES  = 2;
	localparam logic DLSD_BANK_PRIMARY = 1'b0;
	localparam logic [7:0] DLSD_EXP_BIAS = 8'h7F;
	localparam logic [7:0] DLSD_EXP_MAX  = 8'hFE;

	typedef enum logic [2:0] {
		DLSD_OP_ADD = 3'h0,
		DLSD_OP_SUB = 3'h1,
		DLSD_OP_AND = 3'h2,
		DLSD_OP_OR  = 3'h3,
		DLSD_OP_XOR = 3'h4,
		DLSD_OP_PAS = 3'h5,
		DLSD_OP_SHL = 3'h6,
		DLSD_OP_SHR = 3'h7
	} dlsd_op_t;

	typedef enum logic [1:0] {
		DLSD_FMT_FIX = 2'h0,
		DLSD_FMT_F32 = 2'h1,
		DLSD_FMT_F40 = 2'h2
	} dlsd_fmt_t;

	typedef struct packed {
		logic                 valid;
		logic                 alu_en;
		dlsd_op_t             alu_op;
		logic                 mul_en;
		dlsd_fmt_t            fmt;
		logic [DLSD_IDXW-1:0] alu_dst;
		logic [DLSD_IDXW-1:0] alu_a;
		logic [DLSD_IDXW-1:0] alu_b;
		logic [DLSD_IDXW-1:0] mul_dst;
		logic [DLSD_IDXW-1:0] mul_a;
		logic [DLSD_IDXW-1:0] mul_b;
	} dlsd_instr_t;

	typedef struct packed {
		logic                 valid;
		logic                 load;
		logic                 async_mem;
		logic [DLSD_IDXW-1:0] idx;
		logic [DLSD_BUSW-1:0] rdata;
	} dlsd_xfer_t;

	typedef struct packed {
		logic second_lane_enable;
		logic secondary_sel;
	} dlsd_mode_t;

	typedef struct packed {
		logic               alu_vld;
		logic [DLSD_DW-1:0] alu;
		logic               mul_vld;
		logic [DLSD_DW-1:0] mul;
	} dlsd_res_t;
endpackage

// *** verilog/dlsd_datapath.sv ***
// Dual lane SIMD compute datapath: ALU, shifter, multiplier and register file per lane.
// Assumes the sequencer presents one instruction and up to two bus transfers per clock.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RL1] First lane always runs; second lane only when its enable bit is set.
// [RL2] In SIMD mode both lanes run each instruction on their own data.
// [RL3] SIMD mode doubles memory to lane data bandwidth.
// [RL4] SIMD transfers move two values per access, one per lane.
// [RL5] SIMD transfers apply to SDRAM, not to the asynchronous memory interface.
// [RL6] ALU, multiplier and shifter complete each operation in one cycle.
// [RL7] Multifunction instruction runs ALU and multiplier in parallel, in both lanes.
// [RL8] Fixed point, 32-bit float and 40-bit extended float formats supported.
// [RL9] Each lane has ten ports and 32 registers, 16 primary, 16 secondary.
// [RL10] Register file links units to buses and holds intermediate results.
// [RL11] Each lane addresses its registers 0 to 15 in its own name space.
// [RL12] Two 64-bit bus transfers may occur every cycle.
// [RL13] Primary set active after reset; secondary set only when selected.
// [RL14] Registers are 40 bits; bus exchange handles width against 64-bit buses.
// [RL15] Disabled second lane keeps registers and results unchanged.
module dlsd_datapath import dlsd_pkg::*; (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire dlsd_mode_t           mode_i,
	input  wire dlsd_instr_t          instr_i,
	input  wire dlsd_xfer_t           dm_xfer_i,
	input  wire dlsd_xfer_t           pm_xfer_i,
	output logic [DLSD_BUSW-1:0]      dm_wdata_o,
	output logic                      dm_wvld_o,
	output logic [DLSD_BUSW-1:0]      pm_wdata_o,
	output logic                      pm_wvld_o,
	output dlsd_res_t [DLSD_LANES-1:0] lane_res_o,
	output logic                      bank_o
);
	typedef struct packed {
		logic [DLSD_LANES-1:0][DLSD_NREG-1:0][DLSD_DW-1:0] rf;
		logic                                             bank;
		dlsd_res_t [DLSD_LANES-1:0]                       res;
		logic [DLSD_BUSW-1:0]                             dm_wd;
		logic                                             dm_wv;
		logic [DLSD_BUSW-1:0]                             pm_wd;
		logic                                             pm_wv;
	} dlsd_state_t;

	dlsd_state_t s_r, s_nxt;

	function automatic logic [DLSD_DW-1:0] fadd(input logic [DLSD_DW-1:0] a, input logic [DLSD_DW-1:0] b);
		logic [DLSD_DW-1:0] x, y;
		logic [31:0] mx, my;
		logic [32:0] sm;
		logic [7:0]  e, d;
		x = a;
		y = b;
		if (a[38:0] < b[38:0]) begin
			x = b;
			y = a;
		end
		if (y[38:31] == 8'h00)
			return x;
		d  = x[38:31] - y[38:31];
		mx = {1'b1, x[30:0]};
		my = (d > 8'd31) ? 32'h0000_0000 : ({1'b1, y[30:0]} >> d);
		sm = (x[39] == y[39]) ? {1'b0, mx} + {1'b0, my} : {1'b0, mx} - {1'b0, my};
		e  = x[38:31];
		if (sm == 33'h0_0000_0000)
			return '0;
		if (sm[32]) begin
			sm = sm >> 1;
			e  = (e < DLSD_EXP_MAX) ? e + 8'd1 : DLSD_EXP_MAX;
		end
		for (int i = 0; i < 32; i++) begin
			if (!sm[31] && e > 8'd1) begin
				sm = sm << 1;
				e  = e - 8'd1;
			end
		end
		return {x[39], e, sm[30:0]};
	endfunction

	function automatic logic [DLSD_DW-1:0] fmul(input logic [DLSD_DW-1:0] a, input logic [DLSD_DW-1:0] b);
		logic [63:0] p;
		logic [9:0]  e;
		logic [30:0] m;
		if (a[38:31] == 8'h00 || b[38:31] == 8'h00)
			return '0;
		p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
		e = {2'b00, a[38:31]} + {2'b00, b[38:31]} - {2'b00, DLSD_EXP_BIAS};
		m = p[61:31];
		if (p[63]) begin
			m = p[62:32];
			e = e + 10'd1;
		end
		if (e[9] || e == 10'd0)
			return '0;
		if (e > {2'b00, DLSD_EXP_MAX})
			e = {2'b00, DLSD_EXP_MAX};
		return {a[39] ^ b[39], e[7:0], m};
	endfunction

	// 32-bit float keeps only the upper 32 bits
	function automatic logic [DLSD_DW-1:0] fmt_trim(input dlsd_fmt_t f, input logic [DLSD_DW-1:0] v);
		return (f == DLSD_FMT_F40) ? v : {v[DLSD_DW-1:DLSD_PADW], {DLSD_PADW{1'b0}}};
	endfunction

	function automatic logic [DLSD_DW-1:0] alu_f(input dlsd_op_t op, input dlsd_fmt_t f,
		input logic [DLSD_DW-1:0] a, input logic [DLSD_DW-1:0] b);
		logic [31:0] ia, ib, r;
		logic [5:0]  sh;
		ia = a[DLSD_DW-1:DLSD_PADW];
		ib = b[DLSD_DW-1:DLSD_PADW];
		sh = ib[5:0];
		r  = 32'h0000_0000;
		case (op)
			DLSD_OP_ADD: r = ia + ib;
			DLSD_OP_SUB: r = ia - ib;
			DLSD_OP_AND: r = ia & ib;
			DLSD_OP_OR:  r = ia | ib;
			DLSD_OP_XOR: r = ia ^ ib;
			DLSD_OP_PAS: r = ia;
			DLSD_OP_SHL: r = (sh > 6'd31) ? 32'h0000_0000 : ia << sh;
			DLSD_OP_SHR: r = (sh > 6'd31) ? 32'h0000_0000 : ia >> sh;
			default:     r = ia;
		endcase
		if (f != DLSD_FMT_FIX && op == DLSD_OP_ADD)  // [RL8]
			return fmt_trim(f, fadd(a, b));
		if (f != DLSD_FMT_FIX && op == DLSD_OP_SUB)
			return fmt_trim(f, fadd(a, {~b[39], b[38:0]}));
		if (f != DLSD_FMT_FIX && op == DLSD_OP_PAS)
			return fmt_trim(f, a);
		return {r, {DLSD_PADW{1'b0}}};
	endfunction

	function automatic logic [DLSD_DW-1:0] mul_f(input dlsd_fmt_t f, input logic [DLSD_DW-1:0] a,
		input logic [DLSD_DW-1:0] b);
		logic [63:0] p;
		p = a[DLSD_DW-1:DLSD_PADW] * b[DLSD_DW-1:DLSD_PADW];
		if (f == DLSD_FMT_FIX)  // [RL8]
			return {p[31:0], {DLSD_PADW{1'b0}}};
		return fmt_trim(f, fmul(a, b));
	endfunction

	logic                              y_en;
	logic                              dm_dual, pm_dual;
	logic [DLSD_LANES-1:0]             lane_on;
	logic [DLSD_LANES-1:0][DLSD_DW-1:0] alu_v, mul_v, ra, rb, rc, rd;

	assign y_en    = mode_i.second_lane_enable;
	assign lane_on = {y_en, 1'b1};  // [RL1]
	assign dm_dual = y_en && !dm_xfer_i.async_mem;  // [RL5]
	assign pm_dual = y_en && !pm_xfer_i.async_mem;  // [RL5]

	// Each lane reads its own name space through the active bank [RL11] [RL9]
	for (genvar l = 0; l < DLSD_LANES; l++) begin : g_lane
		assign ra[l]    = s_r.rf[l][{s_r.bank, instr_i.alu_a}];
		assign rb[l]    = s_r.rf[l][{s_r.bank, instr_i.alu_b}];
		assign rc[l]    = s_r.rf[l][{s_r.bank, instr_i.mul_a}];
		assign rd[l]    = s_r.rf[l][{s_r.bank, instr_i.mul_b}];
		assign alu_v[l] = alu_f(instr_i.alu_op, instr_i.fmt, ra[l], rb[l]);  // [RL6]
		assign mul_v[l] = mul_f(instr_i.fmt, rc[l], rd[l]);  // [RL6]
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.bank = mode_i.secondary_sel;  // [RL13]
		s_nxt.dm_wv = dm_xfer_i.valid && !dm_xfer_i.load;
		s_nxt.pm_wv = pm_xfer_i.valid && !pm_xfer_i.load;
		// Stores: bus exchange packs lanes side by side in SIMD [RL4] [RL14]
		s_nxt.dm_wd = dm_dual
			? {s_r.rf[1][{s_r.bank, dm_xfer_i.idx}][39:8], s_r.rf[0][{s_r.bank, dm_xfer_i.idx}][39:8]}
			: {24'h00_0000, s_r.rf[0][{s_r.bank, dm_xfer_i.idx}]};
		s_nxt.pm_wd = pm_dual
			? {s_r.rf[1][{s_r.bank, pm_xfer_i.idx}][39:8], s_r.rf[0][{s_r.bank, pm_xfer_i.idx}][39:8]}
			: {24'h00_0000, s_r.rf[0][{s_r.bank, pm_xfer_i.idx}]};
		for (int l = 0; l < DLSD_LANES; l++) begin
			if (lane_on[l]) begin  // [RL15] [RL2]
				s_nxt.res[l].alu_vld = instr_i.valid && instr_i.alu_en;
				s_nxt.res[l].mul_vld = instr_i.valid && instr_i.mul_en;  // [RL7]
				if (instr_i.valid && instr_i.alu_en) begin
					s_nxt.res[l].alu = alu_v[l];
					s_nxt.rf[l][{s_r.bank, instr_i.alu_dst}] = alu_v[l];  // [RL10]
				end
				if (instr_i.valid && instr_i.mul_en) begin
					s_nxt.res[l].mul = mul_v[l];
					s_nxt.rf[l][{s_r.bank, instr_i.mul_dst}] = mul_v[l];
				end
			end else begin
				// Values hold; a valid pulse must not stand while the lane sleeps
				s_nxt.res[l].alu_vld = 1'b0;
				s_nxt.res[l].mul_vld = 1'b0;
			end
		end
		// Loads win over compute writes; two buses every cycle [RL12] [RL3]
		if (pm_xfer_i.valid && pm_xfer_i.load) begin
			s_nxt.rf[0][{s_r.bank, pm_xfer_i.idx}] = pm_dual ? {pm_xfer_i.rdata[31:0], 8'h00} : pm_xfer_i.rdata[39:0];
			if (pm_dual)
				s_nxt.rf[1][{s_r.bank, pm_xfer_i.idx}] = {pm_xfer_i.rdata[63:32], 8'h00};  // [RL4]
		end
		if (dm_xfer_i.valid && dm_xfer_i.load) begin
			s_nxt.rf[0][{s_r.bank, dm_xfer_i.idx}] = dm_dual ? {dm_xfer_i.rdata[31:0], 8'h00} : dm_xfer_i.rdata[39:0];
			if (dm_dual)
				s_nxt.rf[1][{s_r.bank, dm_xfer_i.idx}] = {dm_xfer_i.rdata[63:32], 8'h00};  // [RL4]
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r      <= '0;
			s_r.bank <= DLSD_BANK_PRIMARY;  // [RL13]
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dm_wdata_o = s_r.dm_wd;
	assign dm_wvld_o  = s_r.dm_wv;
	assign pm_wdata_o = s_r.pm_wd;
	assign pm_wvld_o  = s_r.pm_wv;
	assign lane_res_o = s_r.res;
	assign bank_o     = s_r.bank;

	property p_lane_y_hold;
		@(posedge clk_i) disable iff (rst_i)
		!y_en |=> $stable(s_r.rf[1]) && $stable(s_r.res[1].alu) && $stable(s_r.res[1].mul)
			&& !s_r.res[1].alu_vld && !s_r.res[1].mul_vld;
	endproperty
	a_lane_y_hold: assert property (p_lane_y_hold) else $error("Disabled second lane changed"); // [RL15]

	property p_x_always;
		@(posedge clk_i) disable iff (rst_i)
		instr_i.valid && instr_i.alu_en |=> lane_res_o[0].alu_vld;
	endproperty
	a_x_always: assert property (p_x_always) else $error("First lane did not run"); // [RL1]

	property p_simd_both;
		@(posedge clk_i) disable iff (rst_i)
		y_en && instr_i.valid && instr_i.alu_en |=> lane_res_o[1].alu_vld && lane_res_o[0].alu_vld;
	endproperty
	a_simd_both: assert property (p_simd_both) else $error("SIMD did not run both lanes"); // [RL2]

	property p_fix_add;
		@(posedge clk_i) disable iff (rst_i)
		instr_i.valid && instr_i.alu_en && instr_i.alu_op == DLSD_OP_ADD && instr_i.fmt == DLSD_FMT_FIX
		|=> lane_res_o[0].alu[39:8] == $past(ra[0][39:8]) + $past(rb[0][39:8]);
	endproperty
	a_fix_add: assert property (p_fix_add) else $error("Fixed add wrong or late"); // [RL6]

	property p_multifunc;
		@(posedge clk_i) disable iff (rst_i)
		y_en && instr_i.valid && instr_i.alu_en && instr_i.mul_en
		|=> lane_res_o[0].mul_vld && lane_res_o[1].mul_vld && lane_res_o[1].alu_vld;
	endproperty
	a_multifunc: assert property (p_multifunc) else $error("Multifunction pair missing"); // [RL7]

	property p_dual_load;
		@(posedge clk_i) disable iff (rst_i)
		dm_dual && dm_xfer_i.valid && dm_xfer_i.load
		|=> s_r.rf[1][{$past(s_r.bank), $past(dm_xfer_i.idx)}] == {$past(dm_xfer_i.rdata[63:32]), 8'h00};
	endproperty
	a_dual_load: assert property (p_dual_load) else $error("SIMD load did not fill second lane"); // [RL4]

	property p_async_single;
		@(posedge clk_i) disable iff (rst_i)
		dm_xfer_i.valid && !dm_xfer_i.load && dm_xfer_i.async_mem |=> dm_wvld_o && dm_wdata_o[63:40] == 24'h00_0000;
	endproperty
	a_async_single: assert property (p_async_single) else $error("Async store was doubled"); // [RL5]

	property p_two_buses;
		@(posedge clk_i) disable iff (rst_i)
		dm_xfer_i.valid && !dm_xfer_i.load && pm_xfer_i.valid && !pm_xfer_i.load |=> dm_wvld_o && pm_wvld_o;
	endproperty
	a_two_buses: assert property (p_two_buses) else $error("Two bus transfers not served"); // [RL12]

	property p_bank_follow;
		@(posedge clk_i) disable iff (rst_i)
		!mode_i.secondary_sel ##1 !mode_i.secondary_sel |-> bank_o == DLSD_BANK_PRIMARY;
	endproperty
	a_bank_follow: assert property (p_bank_follow) else $error("Secondary set active unselected"); // [RL13]

	c_simd_mf: cover property (@(posedge clk_i) disable iff (rst_i)
		y_en && instr_i.valid && instr_i.alu_en && instr_i.mul_en);
	c_dual_ld: cover property (@(posedge clk_i) disable iff (rst_i)
		dm_dual && dm_xfer_i.valid && dm_xfer_i.load && pm_xfer_i.valid);
	c_bank_sw: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bank_o));
endmodule // dlsd_datapath
`default_nettype wire

// *** bench/dlsd_seq_model.sv ***
// Sequencer and memory bus model that feeds the dual lane datapath.
// Assumes one core clock; drives every request after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dlsd_seq_model import dlsd_pkg::*; (
	input  wire logic  clk_i,
	output dlsd_mode_t  mode_o,
	output dlsd_instr_t instr_o,
	output dlsd_xfer_t  dm_o,
	output dlsd_xfer_t  pm_o
);
	initial begin
		mode_o  = '0;
		instr_o = '0;
		dm_o    = '0;
		pm_o    = '0;
	end
	// Mode change, then one edge to let the bank register follow
	task automatic set_mode(input dlsd_mode_t m);
		@(posedge clk_i);
		mode_o <= m;
		@(posedge clk_i);
	endtask
	// Held for one edge, then dropped
	task automatic issue(input dlsd_instr_t i);
		@(posedge clk_i);
		instr_o <= i;
		@(posedge clk_i);
		instr_o <= '0;
	endtask
	// Released data lines show the inverse of the last value
	task automatic bus(input dlsd_xfer_t d, input dlsd_xfer_t p);
		@(posedge clk_i);
		dm_o <= d;
		pm_o <= p;
		@(posedge clk_i);
		d.valid = 1'b0;
		d.rdata = ~d.rdata;
		p.valid = 1'b0;
		p.rdata = ~p.rdata;
		dm_o <= d;
		pm_o <= p;
	endtask
endmodule // dlsd_seq_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench of the dual lane datapath.
// Assumes the sequencer model in dlsd_seq_model and a 50 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check_val(64'(a), 64'(b))
module tb_top import dlsd_pkg::*;;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	dlsd_mode_t      mode;
	dlsd_instr_t     instr;
	dlsd_xfer_t      dmx;
	dlsd_xfer_t      pmx;
	logic [63:0]     dm_wd;
	logic [63:0]     pm_wd;
	logic            dm_wv;
	logic            pm_wv;
	dlsd_res_t [1:0] res;
	logic            bank;
	int              miscompares = 0;
	int              check_count = 0;
	localparam logic [63:0] D1 = 64'h0000_0030_0000_0007;
	localparam logic [63:0] D2 = 64'h0000_0004_0000_0003;
	localparam logic [63:0] D3 = 64'h0000_00A5_1234_5678;
	always #10 clk = ~clk;
	dlsd_seq_model seq (.clk_i(clk), .mode_o(mode), .instr_o(instr), .dm_o(dmx), .pm_o(pmx));
	dlsd_datapath uut (.clk_i(clk), .rst_i(rst), .mode_i(mode), .instr_i(instr), .dm_xfer_i(dmx),
		.pm_xfer_i(pmx), .dm_wdata_o(dm_wd), .dm_wvld_o(dm_wv), .pm_wdata_o(pm_wd), .pm_wvld_o(pm_wv),
		.lane_res_o(res), .bank_o(bank));
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic dlsd_xfer_t xf(input logic ld, input logic am, input logic [3:0] idx, input logic [63:0] d);
		return '{valid: 1'b1, load: ld, async_mem: am, idx: idx, rdata: d};
	endfunction
	task automatic t_reset();
		`CHK(|res, 1'b0);
		`CHK({dm_wv, pm_wv, bank}, 3'h0);
	endtask
	task automatic t_simd_bus();
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b0});
		seq.bus(xf(1'b1, 1'b0, 4'h1, D1), xf(1'b1, 1'b0, 4'h2, D2));
		seq.bus(xf(1'b0, 1'b0, 4'h1, '0), xf(1'b0, 1'b0, 4'h2, '0));
		#1;
		`CHK({dm_wv, pm_wv}, 2'h3);
		`CHK(dm_wd, D1);
		`CHK(pm_wd, D2);
	endtask
	task automatic t_simd_multi();
		seq.issue('{valid: 1'b1, alu_en: 1'b1, alu_op: DLSD_OP_ADD, mul_en: 1'b1, fmt: DLSD_FMT_FIX,
			alu_dst: 4'h3, alu_a: 4'h1, alu_b: 4'h2, mul_dst: 4'h4, mul_a: 4'h1, mul_b: 4'h2});
		#1;
		`CHK({res[0].alu_vld, res[0].mul_vld, res[1].alu_vld, res[1].mul_vld}, 4'hF);
		`CHK(res[0].alu[39:8], 32'h0000_000A);
		`CHK(res[1].alu[39:8], 32'h0000_0034);
		`CHK(res[0].mul[39:8], 32'h0000_0015);
		`CHK(res[1].mul[39:8], 32'h0000_00C0);
		@(posedge clk);
		#1;
		`CHK({res[0].alu_vld, res[1].mul_vld}, 2'h0);
		seq.bus(xf(1'b0, 1'b0, 4'h3, '0), xf(1'b0, 1'b0, 4'h4, '0));
		#1;
		`CHK(dm_wd, 64'h0000_0034_0000_000A);
		`CHK(pm_wd, 64'h0000_00C0_0000_0015);
	endtask
	task automatic t_lane_off();
		seq.set_mode('{second_lane_enable: 1'b0, secondary_sel: 1'b0});
		seq.issue('{valid: 1'b1, alu_en: 1'b1, alu_op: DLSD_OP_SUB, mul_en: 1'b0, fmt: DLSD_FMT_FIX,
			alu_dst: 4'h3, alu_a: 4'h1, alu_b: 4'h2, mul_dst: 4'h0, mul_a: 4'h0, mul_b: 4'h0});
		#1;
		`CHK({res[0].alu_vld, res[1].alu_vld}, 2'h2);
		`CHK(res[0].alu[39:8], 32'h0000_0004);
		`CHK(res[1].alu[39:8], 32'h0000_0034);
	endtask
	task automatic t_async();
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b0});
		seq.bus(xf(1'b1, 1'b1, 4'h6, D3), xf(1'b0, 1'b1, 4'h6, '0));
		seq.bus(xf(1'b0, 1'b1, 4'h6, '0), xf(1'b0, 1'b1, 4'h6, '0));
		#1;
		`CHK(dm_wd, {24'h00_0000, D3[39:0]});
	endtask
	task automatic t_bank();
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b1});
		#1;
		`CHK(bank, 1'b1);
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b0});
		#1;
		`CHK(bank, DLSD_BANK_PRIMARY);
	endtask
	task automatic t_float_bank();
		seq.bus(xf(1'b1, 1'b0, 4'h7, 64'h3FC0_0000_3F80_0000), xf(1'b1, 1'b0, 4'h8, 64'h4020_0000_4000_0000));
		seq.issue('{valid: 1'b1, alu_en: 1'b1, alu_op: DLSD_OP_ADD, mul_en: 1'b1, fmt: DLSD_FMT_F32,
			alu_dst: 4'h9, alu_a: 4'h7, alu_b: 4'h8, mul_dst: 4'hA, mul_a: 4'h7, mul_b: 4'h8});
		#1;
		`CHK(res[0].alu[39:8], 32'h4040_0000);
		`CHK(res[1].alu[39:8], 32'h4080_0000);
		`CHK(res[0].mul[39:8], 32'h4000_0000);
		`CHK(res[1].mul[39:8], 32'h4070_0000);
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b1});
		seq.bus(xf(1'b1, 1'b0, 4'h7, 64'hFFFF_FFFF_FFFF_FFFF), xf(1'b0, 1'b0, 4'h7, '0));
		#1;
		`CHK(pm_wd, 64'h0000_0000_0000_0000);
		seq.set_mode('{second_lane_enable: 1'b1, secondary_sel: 1'b0});
		seq.bus(xf(1'b0, 1'b0, 4'h7, '0), xf(1'b0, 1'b0, 4'h9, '0));
		#1;
		`CHK(dm_wd, 64'h3FC0_0000_3F80_0000);
		`CHK(pm_wd, 64'h4080_0000_4040_0000);
		seq.issue('{valid: 1'b1, alu_en: 1'b1, alu_op: DLSD_OP_SHL, mul_en: 1'b0, fmt: DLSD_FMT_FIX,
			alu_dst: 4'hB, alu_a: 4'h1, alu_b: 4'h2, mul_dst: 4'h0, mul_a: 4'h0, mul_b: 4'h0});
		#1;
		`CHK(res[0].alu[39:8], 32'h0000_0038);
		`CHK(res[1].alu[39:8], 32'h0000_0300);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_simd_bus();
		t_simd_multi();
		t_lane_off();
		t_async();
		t_bank();
		t_float_bank();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
